/* cssc_top.sv */
// Clock source selection, multipliers, peripheral clock enables and sleep control
// Contract
// - Reset selects the internal RC oscillator for the cpu clock.
// - cpu_clock follows pll_input_clock unless main multiplier enabled and connected; cpu_src_main picks RC or main osc by src_sel bit0, connect bit unused.
// - Main multiplier input selectable RC or main osc; alternate takes main osc.
// - Both multipliers disabled and powered off on reset.
// - USB clock comes from main multiplier route when alternate disabled.
// - Clock sources chosen by select controls, then divided programmably.
// - Each multiplier's oscillator stays within its band; post-dividers reduce output.
// - Multiplier output divider never takes a value below two.
// - RTC oscillator gives a 1 Hz tick and a 32 kHz clock-out source.
// - Watchdog oscillator runs while watchdog enabled; selectable on clock output.
// - At power-up the device runs from RC; main osc unused until enabled.
// - Wake-up timer qualifies main oscillator before it becomes cpu clock.
// - Four reduced-power modes: Sleep, Deep-sleep, Power-down, Deep power-down; only Sleep is a controller state here, the other three just drive lowpower_req.
// - Each peripheral has its own divider and clock gate.
// - Sleep stops the core clock; exit only re-enables it.
// - Sleep suspends execution until reset or interrupt; peripherals keep clocks.
// - Sleep keeps DMA clocked; flash and main SRAM disabled.
// - Any pending enabled interrupt ends Sleep.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module cssc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic main_osc_ok,
    input wire logic irq_pending,
    input wire logic rtc_1hz_in,
    output logic cpu_clk_en,
    output logic cpu_src_main,
    output logic main_pll_pd,
    output logic main_pll_src_main,
    output logic alt_pll_pd,
    output logic usb_from_alt,
    output logic [3:0] main_pll_div,
    output logic [3:0] alt_pll_div,
    output logic [cssc_pkg::N_PERIPH-1:0] periph_clk_en,
    output logic dma_clk_en,
    output logic mem_en,
    output logic main_osc_en,
    output logic wdt_osc_en,
    output logic rtc_tick,
    output logic [1:0] clock_output_pin_sel,
    output logic [2:0] lowpower_req
);
    import cssc_pkg::*;

    typedef struct packed {
        logic aw_full;
        cssc_req_t aw;
        logic w_full;
        logic [31:0] w;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] src_sel;
        logic [15:0] main_pll;
        logic [15:0] alt_pll;
        logic [N_PERIPH-1:0] pen;
        logic [N_PERIPH*DIV_W-1:0] pdiv;
        logic [3:0] power;
        logic [1:0] osc;
        logic [1:0] clock_output_pin;
        logic [15:0] wake_cnt;
        logic osc_qual;
        logic cpu_main;
        logic rtc_s1;
        logic rtc_s2;
        logic rtc_s3;
        logic ok_s1;
        logic ok_s2;
        logic irq_s1;
        logic irq_s2;
        cssc_pmode_t mode;
        logic [N_PERIPH*DIV_W-1:0] pcnt;
        logic [N_PERIPH-1:0] pen_out;
    } cssc_state_t;

    cssc_state_t st_reg;
    cssc_state_t st_next;
    logic [N_PERIPH-1:0] div_hit;

    // ------------------------------------------------------------------
    // Per-peripheral divider terminal count
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < N_PERIPH; gi++) begin : g_div
            assign div_hit[gi] = st_reg.pcnt[gi*DIV_W +: DIV_W]
                == st_reg.pdiv[gi*DIV_W +: DIV_W];
        end
    endgenerate

    function automatic logic [15:0] pll_write(input logic [15:0] cur, input logic [31:0] d);
        logic [15:0] v;
        v = d[15:0];
        // Divider below two would break the 50 percent duty; keep old value
        if (v[PLL_DIV_LSB +: 4] < PLL_DIV_MIN) begin
            v[PLL_DIV_LSB +: 4] = cur[PLL_DIV_LSB +: 4];
        end
        return v;
    endfunction : pll_write

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic wr;
        logic err;
        st_next = st_reg;
        wr = 1'b0;
        err = 1'b0;
        // Synchronisers: first stage read only by the second
        st_next.rtc_s1 = rtc_1hz_in;
        st_next.rtc_s2 = st_reg.rtc_s1;
        st_next.rtc_s3 = st_reg.rtc_s2;
        st_next.ok_s1 = main_osc_ok;
        st_next.ok_s2 = st_reg.ok_s1;
        st_next.irq_s1 = irq_pending;
        st_next.irq_s2 = st_reg.irq_s1;

        if (s_axi_awvalid && !st_reg.aw_full) begin
            st_next.aw_full = 1'b1;
            st_next.aw.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_full) begin
            st_next.w_full = 1'b1;
            st_next.w = s_axi_wdata;
        end
        if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
            wr = 1'b1;
            st_next.aw_full = 1'b0;
            st_next.w_full = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = AXI_OKAY;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        if (wr) begin
            case (st_reg.aw.addr)
                OFS_SRC_SEL: st_next.src_sel = st_reg.w[2:0];
                OFS_MAIN_PLL: st_next.main_pll = pll_write(st_reg.main_pll, st_reg.w);
                OFS_ALT_PLL: st_next.alt_pll = pll_write(st_reg.alt_pll, st_reg.w);
                OFS_PERIPH_EN: st_next.pen = st_reg.w[N_PERIPH-1:0];
                OFS_PERIPH_DIV: st_next.pdiv = st_reg.w[N_PERIPH*DIV_W-1:0];
                OFS_POWER: st_next.power = st_reg.w[3:0];
                OFS_OSC_CTRL: st_next.osc = st_reg.w[1:0];
                OFS_CLOCK_OUTPUT_PIN: st_next.clock_output_pin = st_reg.w[1:0];
                default: err = 1'b1;
            endcase
            if (err) begin
                st_next.bresp = AXI_SLVERR;
            end
        end

        if (s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = AXI_OKAY;
            case (s_axi_araddr)
                OFS_SRC_SEL: st_next.rdata = {29'h0, st_reg.src_sel};
                OFS_MAIN_PLL: st_next.rdata = {16'h0, st_reg.main_pll};
                OFS_ALT_PLL: st_next.rdata = {16'h0, st_reg.alt_pll};
                OFS_PERIPH_EN: st_next.rdata = {28'h0, st_reg.pen};
                OFS_PERIPH_DIV: st_next.rdata = {12'h0, st_reg.pdiv};
                OFS_POWER: st_next.rdata = {28'h0, st_reg.power};
                OFS_OSC_CTRL: st_next.rdata = {30'h0, st_reg.osc};
                OFS_CLOCK_OUTPUT_PIN: st_next.rdata = {30'h0, st_reg.clock_output_pin};
                OFS_STATUS: st_next.rdata = {29'h0, st_reg.mode == ST_SLEEP,
                    st_reg.cpu_main, st_reg.osc_qual};
                default: begin
                    st_next.rdata = 32'h0;
                    st_next.rresp = AXI_SLVERR;
                end
            endcase
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // Main oscillator qualification: stable ok for the wake-up interval
        if (!st_reg.osc[OSC_MAIN_BIT] || !st_reg.ok_s2) begin
            st_next.wake_cnt = 16'h0;
            st_next.osc_qual = 1'b0;
        end else if (st_reg.wake_cnt == 16'(WAKE_CYCLES - 1)) begin
            st_next.osc_qual = 1'b1;
        end else begin
            st_next.wake_cnt = st_reg.wake_cnt + 16'h1;
        end
        // Source switch follows osc_qual in the same cycle and src_sel one cycle later, in run mode as well as while the core is gated
        st_next.cpu_main = st_reg.src_sel[SRC_CPU_BIT] && st_next.osc_qual;

        case (st_reg.mode)
            ST_RUN: begin
                if (st_reg.power[PWR_SLEEP_BIT]) begin
                    st_next.mode = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (st_reg.irq_s2) begin
                    st_next.mode = ST_RUN;
                    st_next.power[PWR_SLEEP_BIT] = 1'b0;
                end
            end
            default: st_next.mode = ST_RUN;
        endcase

        // Divider counters; enable pulses change only at count boundaries
        for (int i = 0; i < N_PERIPH; i++) begin
            if (!st_reg.pen[i] || div_hit[i]) begin
                st_next.pcnt[i*DIV_W +: DIV_W] = '0;
            end else begin
                st_next.pcnt[i*DIV_W +: DIV_W] = st_reg.pcnt[i*DIV_W +: DIV_W] + 5'h1;
            end
            st_next.pen_out[i] = st_reg.pen[i] && div_hit[i];
        end

        if (!aresetn) begin
            st_next = '0;
            st_next.mode = ST_RUN;
            st_next.src_sel = RST_SRC_SEL;
            st_next.main_pll = RST_PLL;
            st_next.alt_pll = RST_PLL;
            st_next.pen = RST_PERIPH_EN;
            st_next.pdiv = RST_PERIPH_DIV;
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = !st_reg.aw_full;
    assign s_axi_wready = !st_reg.w_full;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    assign cpu_clk_en = st_reg.mode == ST_RUN;
    assign cpu_src_main = st_reg.cpu_main;
    assign main_pll_pd = !st_reg.main_pll[PLL_EN_BIT];
    assign alt_pll_pd = !st_reg.alt_pll[PLL_EN_BIT];
    assign main_pll_src_main = st_reg.src_sel[SRC_PLLIN_BIT];
    // Alternate route needs the alternate multiplier enabled; else main route feeds USB
    assign usb_from_alt = st_reg.src_sel[SRC_USB_BIT]
        && st_reg.alt_pll[PLL_EN_BIT];
    assign main_pll_div = st_reg.main_pll[PLL_DIV_LSB +: 4];
    assign alt_pll_div = st_reg.alt_pll[PLL_DIV_LSB +: 4];
    assign periph_clk_en = st_reg.pen_out;
    assign dma_clk_en = 1'b1;
    assign mem_en = st_reg.mode == ST_RUN;
    assign main_osc_en = st_reg.osc[OSC_MAIN_BIT];
    assign wdt_osc_en = st_reg.osc[OSC_WDT_BIT];
    assign rtc_tick = st_reg.rtc_s2 && !st_reg.rtc_s3;
    assign clock_output_pin_sel = st_reg.clock_output_pin;
    assign lowpower_req = st_reg.power[PWR_DPDOWN_BIT:PWR_DSLEEP_BIT];

endmodule : cssc_top

/* cssc_pkg.sv */
// Package: register map, field layout, reset values and timing for the clock/sleep controller
package cssc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_SRC_SEL = 8'h00;
    localparam logic [7:0] OFS_MAIN_PLL = 8'h04;
    localparam logic [7:0] OFS_ALT_PLL = 8'h08;
    localparam logic [7:0] OFS_PERIPH_EN = 8'h0c;
    localparam logic [7:0] OFS_PERIPH_DIV = 8'h10;
    localparam logic [7:0] OFS_POWER = 8'h14;
    localparam logic [7:0] OFS_OSC_CTRL = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_CLOCK_OUTPUT_PIN = 8'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // SRC_SEL: bit0 cpu source (0 internal_rc_osc, 1 main osc),
    // bit1 main_freq_multiplier input (0 rc, 1 main osc), bit2 usb from alt
    localparam int SRC_CPU_BIT = 0;
    localparam int SRC_PLLIN_BIT = 1;
    localparam int SRC_USB_BIT = 2;
    // MAIN_PLL / ALT_PLL: bit0 enable, bit1 connect, [7:4] out divider, [15:8] mult
    localparam int PLL_EN_BIT = 0;
    localparam int PLL_CONN_BIT = 1;
    localparam int PLL_DIV_LSB = 4;
    localparam int PLL_MUL_LSB = 8;
    // POWER: bit0 sleep request, bit1..3 deep-sleep, power-down, deep power-down
    localparam int PWR_SLEEP_BIT = 0;
    localparam int PWR_DSLEEP_BIT = 1;
    localparam int PWR_PDOWN_BIT = 2;
    localparam int PWR_DPDOWN_BIT = 3;
    // OSC_CTRL: bit0 main oscillator enable, bit1 watchdog enable
    localparam int OSC_MAIN_BIT = 0;
    localparam int OSC_WDT_BIT = 1;

    localparam int N_PERIPH = 4;
    localparam int DIV_W = 5;
    localparam logic [3:0] PLL_DIV_MIN = 4'h2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] RST_SRC_SEL = 3'h0;
    localparam logic [15:0] RST_PLL = 16'h0020;
    localparam logic [N_PERIPH-1:0] RST_PERIPH_EN = 4'hf;
    localparam logic [N_PERIPH*DIV_W-1:0] RST_PERIPH_DIV = 20'h00000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int WAKE_US = 10;
    localparam int WAKE_CYCLES = WAKE_US * CLK_MHZ;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum {ST_RUN, ST_SLEEP} cssc_pmode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
    } cssc_req_t;

endpackage : cssc_pkg

/* cssc_top_props.sv */
// Checker for the clock source and sleep controller ports
`timescale 1ns/1ns
module cssc_top_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cpu_src_main,
    input wire logic main_pll_pd,
    input wire logic alt_pll_pd,
    input wire logic [3:0] main_pll_div,
    input wire logic [3:0] alt_pll_div,
    input wire logic main_osc_en,
    input wire logic main_osc_ok,
    input wire logic cpu_clk_en,
    input wire logic irq_pending,
    input wire logic mem_en,
    input wire logic dma_clk_en,
    input wire logic rtc_1hz_in,
    input wire logic rtc_tick
);
    import cssc_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Raw cycles of a running, enabled oscillator; the synchroniser only makes it longer
    int ok_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || !(main_osc_en && main_osc_ok)) ok_cnt <= 0;
        else if (ok_cnt < 4000) ok_cnt <= ok_cnt + 1;
    end
    a_reset_rc_off: assert property ($rose(aresetn) |-> !cpu_src_main && main_pll_pd
        && alt_pll_pd && cpu_clk_en) else $error("reset state of clock selection wrong");
    a_div_min_two: assert property (main_pll_div >= 4'h2 && alt_pll_div >= 4'h2)
        else $error("multiplier divider below two");
    a_osc_qualified: assert property ($rose(cpu_src_main) |-> ok_cnt >= WAKE_CYCLES)
        else $error("main oscillator used before wake-up interval");
    a_osc_loss_drop: assert property ($fell(main_osc_ok) |-> ##[1:5] !cpu_src_main)
        else $error("cpu kept on lost oscillator");
    a_irq_wakes: assert property ($rose(irq_pending) && !cpu_clk_en |-> ##[1:4] cpu_clk_en)
        else $error("pending interrupt did not end sleep");
    a_sleep_gating: assert property (!cpu_clk_en |-> !mem_en && dma_clk_en)
        else $error("sleep gating of memory or dma wrong");
    a_rtc_tick_follow: assert property ($rose(rtc_1hz_in) |-> ##[1:5] rtc_tick)
        else $error("no tick after rtc edge");
    a_tick_one_cycle: assert property (rtc_tick |=> !rtc_tick)
        else $error("tick longer than one cycle");
endmodule : cssc_top_chk

bind cssc_top cssc_top_chk i_cssc_top_chk (.aclk(aclk), .aresetn(aresetn),
    .cpu_src_main(cpu_src_main), .main_pll_pd(main_pll_pd), .alt_pll_pd(alt_pll_pd),
    .main_pll_div(main_pll_div), .alt_pll_div(alt_pll_div), .main_osc_en(main_osc_en),
    .main_osc_ok(main_osc_ok), .cpu_clk_en(cpu_clk_en), .irq_pending(irq_pending),
    .mem_en(mem_en), .dma_clk_en(dma_clk_en), .rtc_1hz_in(rtc_1hz_in), .rtc_tick(rtc_tick));

/* cssc_far_model.sv */
// Model of the oscillator, interrupt source and rtc oscillator around the controller
`timescale 1ns/1ns
module cssc_far_model #(
    parameter int STARTUP = 20,
    parameter int RTC_HALF = 40
) (
    input wire logic aclk,
    input wire logic main_osc_en,
    input wire logic osc_fail,
    input wire logic irq_req,
    output logic main_osc_ok,
    output logic irq_pending,
    output logic rtc_1hz_in
);
    int up = 0;
    int rc = 0;
    initial begin
        main_osc_ok = 1'b0;
        irq_pending = 1'b0;
        rtc_1hz_in = 1'b0;
    end
    // A crystal needs time to build amplitude, so ok never follows enable at once
    always @(posedge aclk) begin
        if (!main_osc_en || osc_fail) up <= 0;
        else if (up < STARTUP) up <= up + 1;
        main_osc_ok <= (up == STARTUP) && !osc_fail;
        irq_pending <= irq_req;
        rc <= (rc == RTC_HALF - 1) ? 0 : rc + 1;
        if (rc == RTC_HALF - 1) rtc_1hz_in <= ~rtc_1hz_in;
    end
endmodule : cssc_far_model

/* cssc_top_tb_top.sv */
// Testbench for the clock source and sleep controller
`timescale 1ns/1ns
module cssc_top_tb_top;
    import cssc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, osc_fail = 1'b0, irq_req = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, main_osc_ok, irq_pending, rtc_1hz_in;
    logic [1:0] bresp, rresp, clock_output_pin_sel;
    logic cpu_clk_en, cpu_src_main, main_pll_pd, main_pll_src_main, alt_pll_pd, usb_from_alt;
    logic dma_clk_en, mem_en, main_osc_en, wdt_osc_en, rtc_tick;
    logic [3:0] main_pll_div, alt_pll_div;
    logic [N_PERIPH-1:0] periph_clk_en;
    logic [2:0] lowpower_req;
    int err_total = 0, checks_done = 0, c0, c1, ct;
    always #5 aclk = ~aclk;
    cssc_top i_cssc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .main_osc_ok(main_osc_ok), .irq_pending(irq_pending), .rtc_1hz_in(rtc_1hz_in),
        .cpu_clk_en(cpu_clk_en), .cpu_src_main(cpu_src_main), .main_pll_pd(main_pll_pd),
        .main_pll_src_main(main_pll_src_main), .alt_pll_pd(alt_pll_pd),
        .usb_from_alt(usb_from_alt), .main_pll_div(main_pll_div), .alt_pll_div(alt_pll_div),
        .periph_clk_en(periph_clk_en), .dma_clk_en(dma_clk_en), .mem_en(mem_en),
        .main_osc_en(main_osc_en), .wdt_osc_en(wdt_osc_en), .rtc_tick(rtc_tick),
        .clock_output_pin_sel(clock_output_pin_sel), .lowpower_req(lowpower_req));
    cssc_far_model i_cssc_far_model (.aclk(aclk), .main_osc_en(main_osc_en),
        .osc_fail(osc_fail), .irq_req(irq_req), .main_osc_ok(main_osc_ok),
        .irq_pending(irq_pending), .rtc_1hz_in(rtc_1hz_in));
    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // Values read right after an edge are the ones that edge sampled
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        bready <= 1'b0;
        if (n >= 40) begin
            err_total++;
            conclude();
        end
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : axw
    task automatic axr(input string nm, input logic [7:0] a, input logic [31:0] ex,
        input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        rready <= 1'b0;
        if (n >= 40) begin
            err_total++;
            conclude();
        end
        chk(nm, ex, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : axr
    task automatic cnt(input int n);
        c0 = 0;
        c1 = 0;
        ct = 0;
        repeat (n) begin
            @(negedge aclk);
            c0 += int'(periph_clk_en[0]);
            c1 += int'(periph_clk_en[1]);
            ct += int'(rtc_tick);
        end
    endtask : cnt
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("cpu_src_main", 0, {31'h0, cpu_src_main});
        chk("pll_pd", 3, {30'h0, main_pll_pd, alt_pll_pd});
        axr("src_sel", OFS_SRC_SEL, 32'h0, AXI_OKAY);
        axr("main_pll", OFS_MAIN_PLL, 32'h20, AXI_OKAY);
        axr("alt_pll", OFS_ALT_PLL, 32'h20, AXI_OKAY);
        axr("periph_en", OFS_PERIPH_EN, 32'hf, AXI_OKAY);
        axr("unmapped", 8'h40, 32'h0, AXI_SLVERR);
        axw(OFS_STATUS, 32'h7, AXI_SLVERR);
        $display("test reset done");
        axw(OFS_MAIN_PLL, 32'h1813, AXI_OKAY);
        axr("main_pll", OFS_MAIN_PLL, 32'h1823, AXI_OKAY);
        chk("main_pd", 0, {31'h0, main_pll_pd});
        axw(OFS_MAIN_PLL, 32'h1831, AXI_OKAY);
        @(negedge aclk);
        chk("main_div", 3, {28'h0, main_pll_div});
        axw(OFS_SRC_SEL, 32'h6, AXI_OKAY);
        @(negedge aclk);
        chk("pll_src", 1, {31'h0, main_pll_src_main});
        chk("usb_alt", 0, {31'h0, usb_from_alt});
        axw(OFS_ALT_PLL, 32'h21, AXI_OKAY);
        axw(OFS_CLOCK_OUTPUT_PIN, 32'h2, AXI_OKAY);
        axw(OFS_OSC_CTRL, 32'h2, AXI_OKAY);
        axw(OFS_POWER, 32'he, AXI_OKAY);
        @(negedge aclk);
        chk("usb_alt", 1, {31'h0, usb_from_alt});
        chk("clock_output_pin_wdt", 32'h5, {29'h0, clock_output_pin_sel, wdt_osc_en});
        chk("lowpower_req", 32'h7, {29'h0, lowpower_req});
        axw(OFS_POWER, 32'h0, AXI_OKAY);
        axw(OFS_PERIPH_DIV, 32'h1, AXI_OKAY);
        axw(OFS_PERIPH_EN, 32'h1, AXI_OKAY);
        cnt(160);
        chk("periph", 32'ha, c0 / 8);
        chk("periph_gated", 0, c1);
        chk("rtc_ticks", 2, ct);
        $display("test setup done");
        axw(OFS_POWER, 32'h1, AXI_OKAY);
        repeat (2) @(negedge aclk);
        chk("sleep_gate", 32'h1, {29'h0, cpu_clk_en, mem_en, dma_clk_en});
        cnt(20);
        chk("sleep_periph", 32'ha, c0);
        axr("status", OFS_STATUS, 32'h4, AXI_OKAY);
        irq_req <= 1'b1;
        repeat (5) @(negedge aclk);
        chk("woken", 1, {31'h0, cpu_clk_en});
        axr("power", OFS_POWER, 32'h0, AXI_OKAY);
        irq_req <= 1'b0;
        $display("test sleep done");
        axw(OFS_SRC_SEL, 32'h1, AXI_OKAY);
        axw(OFS_OSC_CTRL, 32'h1, AXI_OKAY);
        repeat (500) @(negedge aclk);
        chk("early_main", 0, {31'h0, cpu_src_main});
        repeat (600) @(negedge aclk);
        chk("late_main", 1, {31'h0, cpu_src_main});
        axr("status", OFS_STATUS, 32'h3, AXI_OKAY);
        osc_fail <= 1'b1;
        repeat (8) @(negedge aclk);
        chk("lost_main", 0, {31'h0, cpu_src_main});
        $display("test oscillator done");
        conclude();
    end
endmodule : cssc_top_tb_top
